// >>> rtl/pwm_unit_pkg.sv
// Purpose: Constants, types and mode decoding for the PWM waveform unit.
// Assumes: 16-bit counter, register words on a plain strobe port.
// Notes: Shared by the unit top and its compare channel.
//
// Contract
// - Fast PWM, compare BOTTOM: one-tick spike
// - Fast PWM, compare TOP: constant level
// - Mode 15 action 1 toggles channel A
// - Modes 1,2,3,10,11 are phase correct
// - Phase correct TOP fixed, capture or A
// - Dual slope holds TOP one tick
// - Dual slope: clear up, set down
// - Action 2 non-inverted, 3 inverted
// - Phase correct: overflow BOTTOM, TOP flags
// - Phase correct loads buffers at TOP
// - Match flag whenever count equals level
// - Fixed TOP masks compare bits on write
// - Dual slope extremes give constant levels
// - Mode 11 action 1 toggles channel A
// - Modes 8,9 are phase and frequency correct
// - PFC loads at BOTTOM with overflow
// - Mode 9 action 1 toggles channel A
// - Dual slope period is twice TOP ticks
// - Pin driven only with direction bit set
// - Channel A writes go to buffer
// - Nonzero action overrides pin port function
package pwm_unit_pkg;

  // ------------------------------------------------------------
  // Widths and register map
  // ------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int ADDR_W = 5;
  localparam int FLAG_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_CMPA = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_CMPB = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CAPTOP = 5'h10;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 5'h14;
  localparam logic [ADDR_W-1:0] ADDR_PINDIR = 5'h18;

  // Control field positions and flag bit positions.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_W = 8;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MATCHA = 1;
  localparam int FLAG_MATCHB = 2;
  localparam int FLAG_CAPT = 3;
  localparam int DIR_A = 0;
  localparam int DIR_B = 1;

  // ------------------------------------------------------------
  // Counter values, modes and output actions
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] BOTTOM = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] TOP_8 = 16'h00FF;
  localparam logic [CNT_W-1:0] TOP_9 = 16'h01FF;
  localparam logic [CNT_W-1:0] TOP_10 = 16'h03FF;
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV = 2'h3;

  typedef enum logic [1:0] {CLS_NONE, CLS_FAST, CLS_PHASE, CLS_PFC} mode_class_t;
  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

  // Sorts a waveform mode into its counting family.
  function automatic mode_class_t class_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'hA, 4'hB: class_of = CLS_PHASE;
      4'h8, 4'h9: class_of = CLS_PFC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: class_of = CLS_FAST;
      default: class_of = CLS_NONE;
    endcase
  endfunction

  // Resolution mask of the fixed-TOP modes, all ones otherwise.
  function automatic logic [CNT_W-1:0] width_mask(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: width_mask = TOP_8;
      4'h2, 4'h6: width_mask = TOP_9;
      4'h3, 4'h7: width_mask = TOP_10;
      default: width_mask = CNT_MAX;
    endcase
  endfunction

  // True where the capture/TOP register sets the TOP value.
  function automatic logic cap_is_top(input logic [3:0] m);
    cap_is_top = (m == 4'h8) || (m == 4'hA) || (m == 4'hE);
  endfunction

  // True where the channel A compare level sets the TOP value.
  function automatic logic cha_is_top(input logic [3:0] m);
    cha_is_top = (m == 4'h9) || (m == 4'hB) || (m == 4'hF);
  endfunction

endpackage

// >>> rtl/compare_channel.sv
// Purpose: One compare channel: buffered level, match and waveform bit.
// Assumes: Tick, update point and slope come from the counter owner.
// Notes: Toggle action is honoured only when TOGGLE_OK is set.
`timescale 1ns/1ps
module compare_channel #(
  parameter bit TOGGLE_OK = 1'b0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic load_now,
  input wire logic direct,
  input wire logic wr_en,
  input wire logic [pwm_unit_pkg::CNT_W-1:0] wr_data,
  input wire logic mask_now,
  input wire logic [pwm_unit_pkg::CNT_W-1:0] mask,
  input wire logic [1:0] action,
  input wire pwm_unit_pkg::mode_class_t cls,
  input wire logic toggle_mode,
  input wire logic [pwm_unit_pkg::CNT_W-1:0] cnt,
  input wire logic at_top,
  input wire logic slope_up,
  output logic [pwm_unit_pkg::CNT_W-1:0] level_q,
  output logic [pwm_unit_pkg::CNT_W-1:0] buffer_q,
  output logic match,
  output logic wave_q
);
  import pwm_unit_pkg::*;

  logic pwm_act;

  assign match = tick && (cnt == level_q);
  assign pwm_act = (action == ACT_NONINV) || (action == ACT_INV);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_q <= BOTTOM;
    end else if (wr_en) begin
      buffer_q <= wr_data & mask;
    end else if (mask_now) begin
      buffer_q <= buffer_q & mask;
    end
  end

  // Active level follows the buffer at the update point, or takes a write at once when direct.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= BOTTOM;
    end else if (direct && wr_en) begin
      level_q <= wr_data & mask;
    end else if (load_now) begin
      level_q <= buffer_q;
    end else if (mask_now) begin
      level_q <= level_q & mask;
    end
  end

  // Waveform bit; set or clear actions win over toggling.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wave_q <= 1'b0;
    end else if (tick && (cls == CLS_FAST) && pwm_act) begin
      if (at_top) begin
        wave_q <= (action == ACT_NONINV);
      end else if (match) begin
        wave_q <= (action == ACT_INV);
      end
    end else if (tick && (cls != CLS_NONE) && pwm_act && match) begin
      wave_q <= (action == ACT_NONINV) ? !slope_up : slope_up;
    end else if (TOGGLE_OK && toggle_mode && (action == ACT_TOGGLE) && match) begin
      wave_q <= !wave_q;
    end
  end

endmodule

// >>> rtl/pwm_waveform_unit.sv
// Purpose: 16-bit timer waveform unit with fast and dual-slope PWM.
// Assumes: timer_clock_enable is a one-cycle prescaler pulse.
// Notes: Registers sit on a plain strobe port; read data one cycle late.
`timescale 1ns/1ps
module pwm_waveform_unit (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic timer_clock_enable,
  input wire logic [pwm_unit_pkg::ADDR_W-1:0] addr,
  input wire logic [pwm_unit_pkg::CNT_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [pwm_unit_pkg::CNT_W-1:0] rd_data,
  output logic channel_a_output_pin,
  output logic channel_a_output_oe,
  output logic channel_b_output_pin,
  output logic channel_b_output_oe,
  output logic overflow_flag,
  output logic channel_a_match_flag,
  output logic channel_b_match_flag,
  output logic capture_flag
);
  import pwm_unit_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0] timer_count_value_q;
  logic [CNT_W-1:0] capture_top_register_q;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [1:0] pin_direction_bit_q;
  logic [1:0] oe_q;
  logic [CNT_W-1:0] rd_data_q;
  count_dir_t dir_q;

  // ------------------------------------------------------------
  // Decoded control
  // ------------------------------------------------------------
  logic [3:0] waveform_mode_select;
  logic [1:0] channel_a_output_action;
  logic [1:0] channel_b_output_action;
  mode_class_t cls;
  logic dual;
  logic [CNT_W-1:0] top;
  logic [CNT_W-1:0] mask;
  logic at_top;
  logic at_bottom;
  logic slope_up;
  logic tick;
  logic load_now;
  logic toggle_mode;

  // Channel wires.
  logic [CNT_W-1:0] channel_a_compare_level;
  logic [CNT_W-1:0] channel_b_compare_level;
  logic [CNT_W-1:0] buf_a;
  logic [CNT_W-1:0] buf_b;
  logic match_a;
  logic match_b;
  logic wave_a;
  logic wave_b;

  // Bus write strobes.
  logic wr_ctrl;
  logic wr_count;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_captop;
  logic wr_flags;
  logic wr_pindir;
  logic mask_now;

  // Field slices of the control word.
  assign waveform_mode_select = ctrl_q[CTRL_MODE_LSB +: 4];
  assign channel_a_output_action = ctrl_q[CTRL_ACTA_LSB +: 2];
  assign channel_b_output_action = ctrl_q[CTRL_ACTB_LSB +: 2];
  assign cls = class_of(waveform_mode_select);
  assign dual = (cls == CLS_PHASE) || (cls == CLS_PFC);
  assign mask = width_mask(waveform_mode_select);

  assign tick = timer_clock_enable;

  // ------------------------------------------------------------
  // TOP selection and counter position
  // ------------------------------------------------------------

  always_comb begin
    if (cls == CLS_NONE) begin
      top = CNT_MAX;
    end else if (cap_is_top(waveform_mode_select)) begin
      top = capture_top_register_q;
    end else if (cha_is_top(waveform_mode_select)) begin
      top = channel_a_compare_level;
    end else begin
      top = mask;
    end
  end

  assign at_top = (timer_count_value_q == top);
  assign at_bottom = (timer_count_value_q == BOTTOM);

  // Slope seen by the compare actions: TOP counts as falling, BOTTOM as rising.
  assign slope_up = at_bottom || ((dir_q == DIR_UP) && !at_top);

  // Toggle action on channel A: where A sets TOP, or where capture sets a fast TOP.
  assign toggle_mode = (cls != CLS_NONE) && (cha_is_top(waveform_mode_select) ||
                       ((cls == CLS_FAST) && cap_is_top(waveform_mode_select)));

  always_comb begin
    unique case (cls)
      CLS_FAST: load_now = tick && at_top;
      CLS_PHASE: load_now = tick && at_top;
      CLS_PFC: load_now = tick && at_bottom;
      CLS_NONE: load_now = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Register write decode
  // ------------------------------------------------------------

  // One strobe per register; unmapped writes are dropped.
  assign wr_ctrl = wr_en && (addr == ADDR_CTRL);
  assign wr_count = wr_en && (addr == ADDR_COUNT);
  assign wr_cmpa = wr_en && (addr == ADDR_CMPA);
  assign wr_cmpb = wr_en && (addr == ADDR_CMPB);
  assign wr_captop = wr_en && (addr == ADDR_CAPTOP);
  assign wr_flags = wr_en && (addr == ADDR_FLAGS);
  assign wr_pindir = wr_en && (addr == ADDR_PINDIR);

  assign mask_now = (wr_cmpa || wr_cmpb) && (mask != CNT_MAX);

  // Control word holds mode and both output actions.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else if (wr_ctrl) begin
      ctrl_q <= wr_data[CTRL_W-1:0];
    end
  end

  // Capture/TOP register is written directly, never buffered.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_top_register_q <= BOTTOM;
    end else if (wr_captop) begin
      capture_top_register_q <= wr_data;
    end
  end

  // Direction bits of the two compare pins.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_direction_bit_q <= 2'h0;
    end else if (wr_pindir) begin
      pin_direction_bit_q <= wr_data[1:0];
    end
  end

  // ------------------------------------------------------------
  // Counter and direction
  // ------------------------------------------------------------

  // A software write to the count wins over the tick in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count_value_q <= BOTTOM;
    end else if (wr_count) begin
      timer_count_value_q <= wr_data;
    end else if (tick) begin
      unique case (cls)
        CLS_FAST: begin
          timer_count_value_q <= at_top ? BOTTOM : timer_count_value_q + CNT_ONE;
        end
        CLS_PHASE, CLS_PFC: begin
          if (dir_q == DIR_UP) begin
            timer_count_value_q <= at_top ? timer_count_value_q - CNT_ONE
                                          : timer_count_value_q + CNT_ONE;
          end else begin
            timer_count_value_q <= at_bottom ? timer_count_value_q + CNT_ONE
                                             : timer_count_value_q - CNT_ONE;
          end
        end
        CLS_NONE: begin
          timer_count_value_q <= timer_count_value_q + CNT_ONE;
        end
      endcase
    end
  end

  // Direction flips at TOP and at BOTTOM; single-slope modes stay up.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= DIR_UP;
    end else if (!dual) begin
      dir_q <= DIR_UP;
    end else if (tick && !wr_count) begin
      if ((dir_q == DIR_UP) && at_top) begin
        dir_q <= DIR_DOWN;
      end else if ((dir_q == DIR_DOWN) && at_bottom) begin
        dir_q <= DIR_UP;
      end
    end
  end

  // ------------------------------------------------------------
  // Compare channels
  // ------------------------------------------------------------

  // Channel A may set TOP and may toggle.
  compare_channel #(
    .TOGGLE_OK(1'b1)
  ) u_chan_a (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick),
    .load_now(load_now),
    .direct(cls == CLS_NONE),
    .wr_en(wr_cmpa),
    .wr_data(wr_data),
    .mask_now(mask_now),
    .mask(mask),
    .action(channel_a_output_action),
    .cls(cls),
    .toggle_mode(toggle_mode),
    .cnt(timer_count_value_q),
    .at_top(at_top),
    .slope_up(slope_up),
    .level_q(channel_a_compare_level),
    .buffer_q(buf_a),
    .match(match_a),
    .wave_q(wave_a)
  );

  // Channel B never toggles in the PWM modes.
  compare_channel #(
    .TOGGLE_OK(1'b0)
  ) u_chan_b (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(tick),
    .load_now(load_now),
    .direct(cls == CLS_NONE),
    .wr_en(wr_cmpb),
    .wr_data(wr_data),
    .mask_now(mask_now),
    .mask(mask),
    .action(channel_b_output_action),
    .cls(cls),
    .toggle_mode(1'b0),
    .cnt(timer_count_value_q),
    .at_top(at_top),
    .slope_up(slope_up),
    .level_q(channel_b_compare_level),
    .buffer_q(buf_b),
    .match(match_b),
    .wave_q(wave_b)
  );

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------

  // Hardware sets win over a write-one clear in the same cycle.
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = flags_q & ~wr_data[FLAG_W-1:0];
    end
    if (tick) begin
      unique case (cls)
        CLS_FAST: flags_d[FLAG_OVF] = flags_d[FLAG_OVF] | at_top;
        CLS_PHASE, CLS_PFC: flags_d[FLAG_OVF] = flags_d[FLAG_OVF] | at_bottom;
        CLS_NONE: flags_d[FLAG_OVF] = flags_d[FLAG_OVF] | (timer_count_value_q == CNT_MAX);
      endcase
      if ((cls != CLS_NONE) && cap_is_top(waveform_mode_select) && at_top) begin
        flags_d[FLAG_CAPT] = 1'b1;
      end
    end
    flags_d[FLAG_MATCHA] = flags_d[FLAG_MATCHA] | match_a;
    flags_d[FLAG_MATCHB] = flags_d[FLAG_MATCHB] | match_b;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 2'h0;
    end else begin
      oe_q[DIR_A] <= pin_direction_bit_q[DIR_A] && (channel_a_output_action != ACT_OFF);
      oe_q[DIR_B] <= pin_direction_bit_q[DIR_B] && (channel_b_output_action != ACT_OFF);
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------

  // Data stand for one cycle after the read strobe, zero otherwise.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= BOTTOM;
    end else if (rd_en) begin
      case (addr)
        ADDR_CTRL: rd_data_q <= {{(CNT_W-CTRL_W){1'b0}}, ctrl_q};
        ADDR_COUNT: rd_data_q <= timer_count_value_q;
        ADDR_CMPA: rd_data_q <= buf_a;
        ADDR_CMPB: rd_data_q <= buf_b;
        ADDR_CAPTOP: rd_data_q <= capture_top_register_q;
        ADDR_FLAGS: rd_data_q <= {{(CNT_W-FLAG_W){1'b0}}, flags_q};
        ADDR_PINDIR: rd_data_q <= {{(CNT_W-2){1'b0}}, pin_direction_bit_q};
        default: rd_data_q <= BOTTOM;
      endcase
    end else begin
      rd_data_q <= BOTTOM;
    end
  end

  // Outputs straight from flip-flops.
  assign rd_data = rd_data_q;
  assign channel_a_output_pin = wave_a;
  assign channel_b_output_pin = wave_b;
  assign channel_a_output_oe = oe_q[DIR_A];
  assign channel_b_output_oe = oe_q[DIR_B];
  assign overflow_flag = flags_q[FLAG_OVF];
  assign channel_a_match_flag = flags_q[FLAG_MATCHA];
  assign channel_b_match_flag = flags_q[FLAG_MATCHB];
  assign capture_flag = flags_q[FLAG_CAPT];

endmodule

// >>> tb/pwm_load.sv
// Purpose: Load on one PWM pin that counts high cycles and rising edges.
// Assumes: The wire is pulled low whenever the unit does not drive it.
// Notes: Both counters restart while clr is high.
`timescale 1ns/1ps
module pwm_load (
  input wire logic mclk,
  input wire logic pin,
  input wire logic oe,
  input wire logic clr,
  output int high_cnt,
  output int rise_cnt
);
  logic line;
  logic line_q = 1'b0;
  // drive gating
  // The pull-down sets the level whenever the driver is off.
  assign line = oe ? pin : 1'b0;
  // Counts one sample of the wire per clock cycle.
  always @(posedge mclk) begin
    line_q <= line;
    high_cnt <= clr ? 0 : high_cnt + int'(line);
    rise_cnt <= clr ? 0 : rise_cnt + int'(line && !line_q);
  end
endmodule

// >>> tb/pwm_unit_properties.sv
// Purpose: Port-level timing properties of the PWM waveform unit.
// Assumes: One clock domain; flags, pins and drive enables are registered.
// Notes: Bound to every instance of the unit.
`timescale 1ns/1ps
module pwm_unit_checker (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic timer_clock_enable,
  input wire logic [pwm_unit_pkg::ADDR_W-1:0] addr,
  input wire logic wr_en,
  input wire logic channel_a_output_pin,
  input wire logic channel_a_output_oe,
  input wire logic channel_b_output_pin,
  input wire logic channel_b_output_oe,
  input wire logic overflow_flag,
  input wire logic channel_a_match_flag,
  input wire logic capture_flag
);
  import pwm_unit_pkg::*;
  // Every property samples on the rising clock and rests during reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_ovf_tick;
    $rose(overflow_flag) |-> $past(timer_clock_enable);
  endproperty
  a_ovf_tick: assert property (p_ovf_tick)
    else $error("overflow flag rose without a tick");
  property p_match_tick;
    !timer_clock_enable |=> !$rose(channel_a_match_flag);
  endproperty
  a_match_tick: assert property (p_match_tick)
    else $error("match flag rose without a tick");
  property p_capt_tick;
    (!timer_clock_enable)[*2] |=> !$rose(capture_flag);
  endproperty
  a_capt_tick: assert property (p_capt_tick)
    else $error("capture flag rose without a tick");
  property p_pina_tick;
    $changed(channel_a_output_pin) |-> $past(timer_clock_enable);
  endproperty
  a_pina_tick: assert property (p_pina_tick)
    else $error("pin A moved without a tick");
  property p_pinb_tick;
    !timer_clock_enable |=> $stable(channel_b_output_pin);
  endproperty
  a_pinb_tick: assert property (p_pinb_tick)
    else $error("pin B moved without a tick");
  property p_oea_write;
    $changed(channel_a_output_oe) |-> $past(wr_en) || $past(wr_en, 2);
  endproperty
  a_oea_write: assert property (p_oea_write)
    else $error("drive enable A moved without a write");
  property p_oeb_write;
    $changed(channel_b_output_oe) |-> $past(wr_en) || $past(wr_en, 2);
  endproperty
  a_oeb_write: assert property (p_oeb_write)
    else $error("drive enable B moved without a write");
  property p_ovf_clear;
    $fell(overflow_flag) |-> $past(wr_en) && $past(addr) == ADDR_FLAGS;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear)
    else $error("overflow flag fell without a clearing write");
endmodule

bind pwm_waveform_unit pwm_unit_checker chk (.mclk(mclk), .rst_n(rst_n),
  .timer_clock_enable(timer_clock_enable), .addr(addr), .wr_en(wr_en),
  .channel_a_output_pin(channel_a_output_pin), .channel_a_output_oe(channel_a_output_oe),
  .channel_b_output_pin(channel_b_output_pin), .channel_b_output_oe(channel_b_output_oe),
  .overflow_flag(overflow_flag), .channel_a_match_flag(channel_a_match_flag),
  .capture_flag(capture_flag));

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the PWM waveform unit.
// Assumes: Registers are reached over the strobe port, one access at a time.
// Notes: Each table row sets a mode, then checks pins, count shape and flags.
`timescale 1ns/1ps
module testbench;
  import pwm_unit_pkg::*;
  typedef struct {int mode; int top; int lvl; int act; int bh; int dv;} row_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic timer_clock_enable = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [CNT_W-1:0] wr_data = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic clr = 1'b1;
  logic [CNT_W-1:0] rd_data;
  logic pin_a, oe_a, pin_b, oe_b, ovf, mfa, mfb, capf;
  int high_a, rise_a, high_b, rise_b;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int pc = 0;
  int div = 1;
  int per, w, i0, k, e;
  logic [CNT_W-1:0] top, mx;
  logic [CNT_W-1:0] samp [0:2099];
  row_t rw;
  row_t rows [0:12] = '{'{11, 3, 1, 2, 4, 1}, '{11, 3, 1, 3, 8, 1}, '{11, 3, 0, 2, 0, 1},
    '{11, 3, 3, 2, 12, 1}, '{11, 3, 0, 3, 12, 1}, '{9, 5, 1, 2, 4, 1}, '{10, 4, 1, 2, 4, 1},
    '{8, 6, 1, 2, 4, 1}, '{15, 3, 0, 2, 2, 1}, '{15, 3, 3, 2, 8, 1}, '{15, 3, 3, 3, 0, 1},
    '{14, 3, 1, 2, 4, 1}, '{11, 3, 1, 2, 32, 8}};

  pwm_waveform_unit uut (.mclk(mclk), .rst_n(rst_n), .timer_clock_enable(timer_clock_enable),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .channel_a_output_pin(pin_a), .channel_a_output_oe(oe_a), .channel_b_output_pin(pin_b),
    .channel_b_output_oe(oe_b), .overflow_flag(ovf), .channel_a_match_flag(mfa),
    .channel_b_match_flag(mfb), .capture_flag(capf));
  pwm_load la (.mclk(mclk), .pin(pin_a), .oe(oe_a), .clr(clr), .high_cnt(high_a),
    .rise_cnt(rise_a));
  pwm_load lb (.mclk(mclk), .pin(pin_b), .oe(oe_b), .clr(clr), .high_cnt(high_b),
    .rise_cnt(rise_b));

  // Free-running clock of 25 ns.
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // Prescaler ticks every div cycles; a hung run is cut short here.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    pc <= pc + 1;
    timer_clock_enable <= (pc % div) == 0;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      wrap_up();
    end
  end

  // ----------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // Back-to-back reads; samp[i] holds the answer to the i-th strobe.
  task automatic rd_burst(input logic [ADDR_W-1:0] a, input int n);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr <= a;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      if (i == n - 1) rd_en <= 1'b0;
      #1 samp[i] = rd_data;
    end
  endtask

  // Lets the loads count over exactly n cycles.
  task automatic measure(input int n);
    @(posedge mclk);
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd_burst(ADDR_CTRL, 1);
    chk(samp[0], 16'h0000);
    rd_burst(5'h1C, 1);
    chk(samp[0], 16'h0000);
    wr(ADDR_PINDIR, 16'h0003);
    foreach (rows[r]) begin
      rw = rows[r];
      per = (rw.mode >= 14) ? rw.top + 1 : 2 * rw.top;
      w = 2 * per * rw.dv;
      div = rw.dv;
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_CMPA, 16'(rw.top));
      wr(ADDR_CAPTOP, 16'(rw.top));
      wr(ADDR_CMPB, 16'(rw.lvl));
      wr(ADDR_CTRL, 16'(rw.mode + rw.act * 64 + 16));
      wr(ADDR_COUNT, 16'h0000);
      repeat (2 * w) @(posedge mclk);
      measure(w);
      chk(16'(high_b), 16'(rw.bh));
      chk(16'(rise_b), 16'((rw.bh == 0 || rw.bh == w) ? 0 : 2));
      if (rw.mode != 8 && rw.mode != 10) chk(16'(high_a), 16'(w / 2));
      else chk(16'(rise_a), 16'h0000);
      rd_burst(ADDR_COUNT, 2 * w);
      i0 = 1;
      while (i0 < w && !(samp[i0] == rw.top && samp[i0 - 1] != rw.top)) begin
        i0++;
      end
      for (int j = 0; j < w; j++) begin
        k = j / rw.dv;
        e = (k + rw.top) % (rw.top + 1);
        if (rw.mode < 14) e = (k % per <= rw.top) ? rw.top - k % per : k % per - rw.top;
        chk(samp[i0 + j], 16'(e));
      end
      wr(ADDR_FLAGS, 16'h000F);
      repeat (w) @(posedge mclk);
      #1;
      chk(16'(ovf), 16'h0001);
      chk(16'(mfb), 16'h0001);
      chk(16'(mfa), 16'h0001);
      chk(16'(capf), 16'(rw.mode == 8 || rw.mode == 10 || rw.mode == 14));
    end
    div = 1;
    for (int m = 1; m <= 3; m++) begin
      top = (16'h0100 << (m - 1)) - 16'h0001;
      wr(ADDR_CTRL, 16'(m + 128));
      wr(ADDR_COUNT, 16'h0000);
      wr(ADDR_CMPB, 16'hFFFF);
      rd_burst(ADDR_CMPB, 1);
      chk(samp[0], top);
      rd_burst(ADDR_COUNT, 2 * int'(top) + 4);
      mx = 16'h0000;
      for (int i = 0; i < 2 * int'(top) + 4; i++) begin
        if (samp[i] > mx) mx = samp[i];
      end
      chk(mx, top);
    end
    #1;
    chk(16'(oe_a), 16'h0000);
    chk(16'(oe_b), 16'h0001);
    wr(ADDR_PINDIR, 16'h0001);
    repeat (3) @(posedge mclk);
    #1;
    chk(16'(oe_b), 16'h0000);
    wrap_up();
  end
endmodule
